// *** mie_core.sv ***
// Purpose: execute unit for a subset of an 8-bit controller instruction set
// Assumes: one instruction cycle per MCLK edge while the run bit is set
// Notes:   fetch runs one word ahead; a flushed fetch executes as no-op
//
// Chosen here: the address map and the APB slave port.
`default_nettype none
`timescale 1ns/1ns
module mie_core
    import mie_pkg::*;
(
    input  wire logic        MCLK,
    input  wire logic        ARST_N,
    output logic      [12:0] PROG_ADDR,
    input  wire logic [13:0] PROG_DATA,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR
);
    // ********************************
    // state
    // ********************************
    logic [12:0] pc;
    logic [13:0] ir;
    logic [7:0]  accum;
    logic [7:0]  status;
    logic [7:0]  pc_high_latch;
    logic        run;
    logic        flush;
    logic [7:0]  wdog_count;
    logic [7:0]  wdog_presc;
    logic [6:0]  file_idx;

    // ********************************
    // decode
    // ********************************
    logic [5:0]  op6;
    logic        dest_bit;
    logic [6:0]  reg_addr;
    logic [10:0] lit;
    logic        is_call;
    logic        is_wdclr;
    logic        is_comp;
    logic        is_dec;
    logic        is_decskip;
    logic        is_regclr;
    logic        is_accclr;
    logic        has_dest;

    assign op6        = ir[13:8];
    assign dest_bit   = ir[7];
    assign reg_addr   = ir[6:0];
    assign lit        = ir[10:0];
    assign is_call    = run && (ir[13:11] == MIE_OP3_CALL);
    assign is_wdclr   = run && (ir == MIE_INSN_WDCLR);
    assign is_comp    = run && (op6 == MIE_OP6_COMP);
    assign is_dec     = run && (op6 == MIE_OP6_DEC);
    assign is_decskip = run && (op6 == MIE_OP6_DECSKIP);
    assign is_regclr  = run && (op6 == MIE_OP6_CLEAR) && dest_bit;
    assign is_accclr  = run && (op6 == MIE_OP6_CLEAR) && !dest_bit;
    assign has_dest   = is_comp || is_dec || is_decskip;

    // ********************************
    // datapath
    // ********************************
    logic [7:0]  fval;
    logic [7:0]  fdata_b;
    logic [7:0]  comp_val;
    logic [7:0]  dec_val;
    logic [7:0]  result;
    logic        result_zero;
    logic        wr_acc;
    logic        wr_file;
    logic        fw_en;
    logic [6:0]  fw_addr;
    logic [7:0]  fw_data;
    logic        skip;
    logic        discard;
    logic        apb_wr;
    logic [12:0] call_target;
    logic [12:0] next_pc;
    logic [12:0] stack_top;

    assign comp_val    = ~fval;
    assign dec_val     = fval - 8'h01;
    assign result      = is_comp ? comp_val : (has_dest ? dec_val : MIE_RST_BYTE);
    assign result_zero = (result == 8'h00);
    assign wr_acc      = (has_dest && !dest_bit) || is_accclr;
    assign wr_file     = (has_dest && dest_bit) || is_regclr;
    assign skip        = is_decskip && result_zero;
    assign discard     = is_call || skip;
    assign call_target = {pc_high_latch[4:3], lit};
    assign next_pc     = is_call ? call_target : pc + 13'h0001;

    // core writes while running, software loads registers while halted
    assign fw_en   = run ? wr_file : (apb_wr && (PADDR == MIE_OFS_FDATA));
    assign fw_addr = run ? reg_addr : file_idx;
    assign fw_data = run ? result : PWDATA[7:0];

    mie_file_regs u_file (
        .clk     (MCLK),
        .rst_n   (ARST_N),
        .we      (fw_en),
        .waddr   (fw_addr),
        .wdata   (fw_data),
        .raddr_a (reg_addr),
        .rdata_a (fval),
        .raddr_b (file_idx),
        .rdata_b (fdata_b)
    );

    mie_ret_stack u_stack (
        .clk       (MCLK),
        .rst_n     (ARST_N),
        .push      (is_call),
        .push_data (pc),
        .top       (stack_top)
    );

    // ********************************
    // fetch and program counter
    // ********************************
    assign PROG_ADDR = pc;

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pc    <= MIE_RST_PC;
            ir    <= MIE_INSN_NOP;
            flush <= 1'b0;
        end else if (run) begin
            pc    <= next_pc;
            ir    <= discard ? MIE_INSN_NOP : PROG_DATA;
            flush <= discard;
        end
    end

    // ********************************
    // accumulator
    // ********************************
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            accum <= MIE_RST_BYTE;
        end else if (wr_acc) begin
            accum <= is_accclr ? MIE_RST_BYTE : result;
        end
    end

    // ********************************
    // watchdog, prescaler gives tick enable
    // ********************************
    logic wdog_tick;
    logic wdog_expire;

    assign wdog_tick   = (wdog_presc == MIE_WDOG_PRESC_MAX);
    assign wdog_expire = wdog_tick && (wdog_count == MIE_WDOG_COUNT_MAX);

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wdog_presc <= MIE_RST_BYTE;
            wdog_count <= MIE_RST_BYTE;
        end else if (is_wdclr) begin
            wdog_presc <= MIE_RST_BYTE;
            wdog_count <= MIE_RST_BYTE;
        end else begin
            wdog_presc <= wdog_presc + 8'h01;
            if (wdog_tick) begin
                wdog_count <= wdog_count + 8'h01;
            end
        end
    end

    // ********************************
    // status, hardware effects win over software writes
    // ********************************
    logic       st_wr;
    logic [7:0] next_status;
    logic       null_upd;
    logic       null_force;

    assign null_upd   = is_comp || is_dec;
    assign null_force = is_regclr || is_accclr;

    always_comb begin
        next_status = st_wr ? PWDATA[7:0] : status;
        if (null_force) begin
            next_status[MIE_ST_NULL] = 1'b1;
        end else if (null_upd) begin
            next_status[MIE_ST_NULL] = result_zero;
        end
        if (is_wdclr) begin
            next_status[MIE_ST_TIMEOUT] = 1'b1;
            next_status[MIE_ST_SLEEP]   = 1'b1;
        end else if (wdog_expire) begin
            next_status[MIE_ST_TIMEOUT] = 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            status <= MIE_RST_STATUS;
        end else begin
            status <= next_status;
        end
    end

    // ********************************
    // apb slave, zero wait states
    // ********************************
    logic hit;
    logic ctrl_wr;
    logic pclat_wr;
    logic fidx_wr;

    assign apb_wr   = PSEL && PENABLE && PWRITE;
    assign st_wr    = apb_wr && (PADDR == MIE_OFS_STATUS);
    assign ctrl_wr  = apb_wr && (PADDR == MIE_OFS_CTRL);
    assign pclat_wr = apb_wr && (PADDR == MIE_OFS_PCLAT);
    assign fidx_wr  = apb_wr && (PADDR == MIE_OFS_FIDX);
    assign hit      = (PADDR == MIE_OFS_CTRL) || (PADDR == MIE_OFS_STATUS)
                   || (PADDR == MIE_OFS_ACCUM) || (PADDR == MIE_OFS_PCNT)
                   || (PADDR == MIE_OFS_PCLAT) || (PADDR == MIE_OFS_WDOG)
                   || (PADDR == MIE_OFS_STACK) || (PADDR == MIE_OFS_FIDX)
                   || (PADDR == MIE_OFS_FDATA);
    assign PREADY   = 1'b1;
    assign PSLVERR  = PSEL && PENABLE && !hit;

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            run      <= 1'b0;
            pc_high_latch <= MIE_RST_BYTE;
            file_idx <= 7'h00;
        end else begin
            if (ctrl_wr) begin
                run <= PWDATA[MIE_CTRL_RUN];
            end
            if (pclat_wr) begin
                pc_high_latch <= PWDATA[7:0];
            end
            if (fidx_wr) begin
                file_idx <= PWDATA[6:0];
            end
        end
    end

    logic [31:0] next_prdata;

    always_comb begin
        case (PADDR)
            MIE_OFS_CTRL:   next_prdata = {31'h0000_0000, run};
            MIE_OFS_STATUS: next_prdata = {24'h00_0000, status};
            MIE_OFS_ACCUM:  next_prdata = {24'h00_0000, accum};
            MIE_OFS_PCNT:   next_prdata = {19'h0_0000, pc};
            MIE_OFS_PCLAT:  next_prdata = {24'h00_0000, pc_high_latch};
            MIE_OFS_WDOG:   next_prdata = {16'h0000, wdog_presc, wdog_count};
            MIE_OFS_STACK:  next_prdata = {19'h0_0000, stack_top};
            MIE_OFS_FIDX:   next_prdata = {25'h000_0000, file_idx};
            MIE_OFS_FDATA:  next_prdata = {24'h00_0000, fdata_b};
            default:        next_prdata = 32'h0000_0000;
        endcase
    end

    // read data held in flip-flops, loaded in the setup cycle
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PRDATA <= 32'h0000_0000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= next_prdata;
        end
    end

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!ARST_N);

    chk_wdog_count_clear: assert property (
        is_wdclr |=> (wdog_count == 8'h00) ##1 (wdog_count == 8'h00))
        else $error("watchdog count not cleared");

    chk_wdog_presc_clear: assert property (
        is_wdclr |=> (wdog_presc == 8'h00) ##1 (wdog_presc == 8'h01))
        else $error("watchdog prescaler not cleared");

    chk_wdog_flags_set: assert property (
        is_wdclr && !st_wr |=> status[MIE_ST_TIMEOUT] && status[MIE_ST_SLEEP]
            && (status[MIE_ST_NULL] == $past(status[MIE_ST_NULL])))
        else $error("clear watchdog flag effect wrong");

    chk_call_push_ret: assert property (
        is_call |=> (stack_top == $past(pc)))
        else $error("return address not pushed");

    chk_call_target_pc: assert property (
        is_call |=> (pc == {$past(pc_high_latch[4:3]), $past(lit)}))
        else $error("call target wrong");

    chk_call_two_cycle: assert property (
        is_call && !st_wr |=> (status == $past(status)) && (ir == MIE_INSN_NOP))
        else $error("call not two cycles or flags changed");

    chk_comp_to_accum: assert property (
        is_comp && !dest_bit |=> (accum == ~$past(fval)))
        else $error("complement result wrong");

    chk_dest_to_file: assert property (
        has_dest && dest_bit |-> fw_en && (fw_addr == reg_addr) && !wr_acc)
        else $error("destination routing wrong");

    chk_regclr_null_set: assert property (
        is_regclr |-> fw_en && (fw_data == 8'h00) ##1 status[MIE_ST_NULL])
        else $error("clear register effect wrong");

    chk_accclr_zero: assert property (
        is_accclr |=> (accum == 8'h00) && status[MIE_ST_NULL])
        else $error("clear accumulator effect wrong");

    chk_dec_null_flag: assert property (
        is_dec |=> (status[MIE_ST_NULL] == ($past(dec_val) == 8'h00)))
        else $error("decrement null flag wrong");

    chk_decskip_no_flag: assert property (
        is_decskip && !st_wr |=> (status == $past(status)))
        else $error("decrement skip changed a flag");

    chk_skip_inserts_nop: assert property (
        skip |=> flush && (ir == MIE_INSN_NOP) && (pc == $past(pc) + 13'h0001))
        else $error("skip did not discard next word");

    chk_null_tracks_zero: assert property (
        is_comp |=> (status[MIE_ST_NULL] == ($past(comp_val) == 8'h00)))
        else $error("null flag does not track result");
endmodule
`default_nettype wire

// *** mie_file_regs.sv ***
// Purpose: 128 byte file register array in flip-flops
// Assumes: one write port, two read ports
// Notes:   entries clear on reset
`default_nettype none
`timescale 1ns/1ns
module mie_file_regs
    import mie_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       we,
    input  wire logic [6:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic [6:0] raddr_a,
    output logic      [7:0] rdata_a,
    input  wire logic [6:0] raddr_b,
    output logic      [7:0] rdata_b
);
    logic [7:0] mem [MIE_FDEPTH];

    // ********************************
    // storage, one entry per loop step
    // ********************************
    for (genvar i = 0; i < MIE_FDEPTH; i++) begin : g_ent
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                mem[i] <= MIE_RST_BYTE;
            end else if (we && (waddr == 7'(i))) begin
                mem[i] <= wdata;
            end
        end
    end

    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];
endmodule
`default_nettype wire

// *** mie_pkg.sv ***
// Purpose: shared constants of the instruction subset execution core
// Assumes: 14-bit instruction words, 13-bit program counter
// Notes:   register offsets are byte addresses on a 32-bit APB
`default_nettype none
package mie_pkg;
    // ********************************
    // widths
    // ********************************
    localparam int MIE_IW        = 14;
    localparam int MIE_PCW       = 13;
    localparam int MIE_FDEPTH    = 128;
    localparam int MIE_SDEPTH    = 8;
    // ********************************
    // encodings
    // ********************************
    localparam logic [13:0] MIE_INSN_NOP    = 14'h0000;
    localparam logic [13:0] MIE_INSN_WDCLR  = 14'h0064;
    localparam logic [2:0]  MIE_OP3_CALL    = 3'h4;
    localparam logic [5:0]  MIE_OP6_CLEAR   = 6'h01;
    localparam logic [5:0]  MIE_OP6_DEC     = 6'h03;
    localparam logic [5:0]  MIE_OP6_COMP    = 6'h09;
    localparam logic [5:0]  MIE_OP6_DECSKIP = 6'h0B;
    // ********************************
    // register offsets
    // ********************************
    localparam logic [7:0] MIE_OFS_CTRL   = 8'h00;
    localparam logic [7:0] MIE_OFS_STATUS = 8'h04;
    localparam logic [7:0] MIE_OFS_ACCUM  = 8'h08;
    localparam logic [7:0] MIE_OFS_PCNT   = 8'h0C;
    localparam logic [7:0] MIE_OFS_PCLAT  = 8'h10;
    localparam logic [7:0] MIE_OFS_WDOG   = 8'h14;
    localparam logic [7:0] MIE_OFS_STACK  = 8'h18;
    localparam logic [7:0] MIE_OFS_FIDX   = 8'h1C;
    localparam logic [7:0] MIE_OFS_FDATA  = 8'h20;
    // ********************************
    // field positions and reset values
    // ********************************
    localparam int MIE_ST_NULL    = 2;
    localparam int MIE_ST_SLEEP   = 3;
    localparam int MIE_ST_TIMEOUT = 4;
    localparam int MIE_CTRL_RUN   = 0;
    localparam logic [7:0]  MIE_RST_STATUS = 8'h18;
    localparam logic [7:0]  MIE_RST_BYTE   = 8'h00;
    localparam logic [12:0] MIE_RST_PC     = 13'h0000;
    localparam logic [7:0]  MIE_WDOG_PRESC_MAX = 8'hFF;
    localparam logic [7:0]  MIE_WDOG_COUNT_MAX = 8'hFF;
endpackage
`default_nettype wire

// *** mie_prog_mem.sv ***
// Purpose: program memory model feeding instruction words to the core
// Assumes: combinational read, word at the address seen in the same cycle
// Notes:   the bench loads words into the array by hierarchy
`timescale 1ns/1ns
`default_nettype none
module mie_prog_mem
    import mie_pkg::*;
(
    input  wire logic [12:0] addr,
    output logic      [13:0] data
);
    // ********************************
    // storage
    // ********************************
    logic [13:0] words [0:8191];

    assign data = words[addr];
endmodule
`default_nettype wire

// *** mie_ret_stack.sv ***
// Purpose: circular hardware return stack
// Assumes: push only in this subset
// Notes:   ninth push overwrites the oldest entry
`default_nettype none
`timescale 1ns/1ns
module mie_ret_stack
    import mie_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        push,
    input  wire logic [12:0] push_data,
    output logic      [12:0] top
);
    logic [12:0] ent [MIE_SDEPTH];
    logic [2:0]  idx;
    logic [2:0]  next_idx;

    assign next_idx = idx + 3'h1;
    assign top      = ent[idx];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx <= 3'h0;
        end else if (push) begin
            idx <= next_idx;
        end
    end

    for (genvar i = 0; i < MIE_SDEPTH; i++) begin : g_ent
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                ent[i] <= MIE_RST_PC;
            end else if (push && (next_idx == 3'(i))) begin
                ent[i] <= push_data;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench of the instruction subset execute core
// Assumes: halted core accepts file register writes over the register bus
// Notes:   the watchdog, call and ops scenarios reset the core and run a short program
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin \
    checks++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("[ERR] %s expected %0h seen %0h", nm, e, g); \
    end \
end
module tb_top
    import mie_pkg::*;
;
    typedef struct {
        logic [13:0] insn;
        logic [7:0]  val;
        logic [7:0]  acc;
        logic [7:0]  fv;
        logic        nul;
        logic        fol;
        logic [7:0]  f11;
    } mie_case_t;

    logic        mclk;
    logic        arst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [12:0] prog_addr;
    logic [13:0] prog_data;
    int          err_count = 0;
    int          checks = 0;
    int          cyc = 0;

    mie_core dut (
        .MCLK      (mclk),
        .ARST_N    (arst_n),
        .PROG_ADDR (prog_addr),
        .PROG_DATA (prog_data),
        .PSEL      (psel),
        .PENABLE   (penable),
        .PWRITE    (pwrite),
        .PADDR     (paddr),
        .PWDATA    (pwdata),
        .PRDATA    (prdata),
        .PREADY    (pready),
        .PSLVERR   (pslverr)
    );

    mie_prog_mem pm (
        .addr (prog_addr),
        .data (prog_data)
    );

    // ********************************
    // clock, timeout and verdict
    // ********************************
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            wrap_up();
        end
    end

    // ********************************
    // bus and program helpers
    // ********************************
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdv, output logic err);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, wd, r, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] rdv);
        logic e;
        apb(1'b0, a, 32'h0000_0000, rdv, e);
    endtask

    task automatic poke(input logic [6:0] a, input logic [7:0] v);
        wr(MIE_OFS_FIDX, {25'h000_0000, a});
        wr(MIE_OFS_FDATA, {24'h00_0000, v});
    endtask

    task automatic peek(input logic [6:0] a, output logic [7:0] v);
        logic [31:0] d;
        wr(MIE_OFS_FIDX, {25'h000_0000, a});
        rd(MIE_OFS_FDATA, d);
        v = d[7:0];
    endtask

    task automatic do_reset;
        arst_n <= 1'b0;
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        for (int i = 0; i < 8192; i++) begin
            pm.words[i] = MIE_INSN_NOP;
        end
    endtask

    task automatic run(input int n);
        wr(MIE_OFS_CTRL, 32'h0000_0001);
        repeat (n) @(posedge mclk);
        wr(MIE_OFS_CTRL, 32'h0000_0000);
    endtask

    // ********************************
    // scenarios
    // ********************************
    task automatic sc_watchdog;
        logic [31:0] d;
        do_reset();
        pm.words[420] = MIE_INSN_WDCLR;
        wr(MIE_OFS_STATUS, 32'h0000_0004);
        run(440);
        rd(MIE_OFS_STATUS, d);
        `CHK("status", 32'h0000_001C, d)
        rd(MIE_OFS_WDOG, d);
        `CHK("wdog_count", 8'h00, d[7:0])
        `CHK("wdog_presc_low", 1'b1, d[15:8] < 8'h40)
    endtask

    task automatic sc_call;
        logic [31:0] d;
        logic [7:0]  v;
        do_reset();
        poke(7'h21, 8'h43);
        poke(7'h20, 8'hAA);
        wr(MIE_OFS_PCLAT, 32'h0000_0017);
        pm.words[0] = {MIE_OP6_DEC, 1'b0, 7'h21};
        pm.words[1] = {MIE_OP3_CALL, 11'h7FF};
        pm.words[2] = {MIE_OP6_CLEAR, 1'b0, 7'h00};
        pm.words[13'h17FF] = {MIE_OP6_COMP, 1'b1, 7'h20};
        run(20);
        rd(MIE_OFS_STACK, d);
        `CHK("stack_top", 13'h0002, d[12:0])
        peek(7'h20, v);
        `CHK("target_word", 8'h55, v)
        rd(MIE_OFS_ACCUM, d);
        `CHK("accum", 8'h42, d[7:0])
        rd(MIE_OFS_STATUS, d);
        `CHK("status", 8'h18, d[7:0])
    endtask

    task automatic sc_ops;
        mie_case_t   tc [8];
        logic [31:0] d;
        logic [7:0]  v;
        tc = '{
            '{{MIE_OP6_COMP, 1'b1, 7'h7F}, 8'hFF, 8'hFF, 8'h00, 1'b1, 1'b0, 8'h00},
            '{{MIE_OP6_COMP, 1'b0, 7'h05}, 8'h0F, 8'hF0, 8'h0F, 1'b0, 1'b0, 8'h00},
            '{{MIE_OP6_DEC, 1'b1, 7'h00}, 8'h01, 8'hFF, 8'h00, 1'b1, 1'b0, 8'h00},
            '{{MIE_OP6_DEC, 1'b0, 7'h40}, 8'h80, 8'h7F, 8'h80, 1'b0, 1'b0, 8'h00},
            '{{MIE_OP6_CLEAR, 1'b1, 7'h33}, 8'h9C, 8'hFF, 8'h00, 1'b1, 1'b0, 8'h00},
            '{{MIE_OP6_CLEAR, 1'b0, 7'h00}, 8'h5A, 8'h00, 8'h5A, 1'b1, 1'b0, 8'h00},
            '{{MIE_OP6_DECSKIP, 1'b1, 7'h10}, 8'h01, 8'hFF, 8'h00, 1'b0, 1'b1, 8'h00},
            '{{MIE_OP6_DECSKIP, 1'b0, 7'h10}, 8'h03, 8'h02, 8'h03, 1'b0, 1'b1, 8'hFF}
        };
        for (int i = 0; i < 8; i++) begin
            do_reset();
            poke(tc[i].insn[6:0], tc[i].val);
            pm.words[0] = {MIE_OP6_COMP, 1'b0, 7'h02};
            pm.words[1] = tc[i].insn;
            if (tc[i].fol) begin
                pm.words[2] = {MIE_OP6_COMP, 1'b1, 7'h11};
            end
            run(10);
            rd(MIE_OFS_ACCUM, d);
            `CHK("accum", tc[i].acc, d[7:0])
            peek(tc[i].insn[6:0], v);
            `CHK("file_reg", tc[i].fv, v)
            rd(MIE_OFS_STATUS, d);
            `CHK("status", {3'b000, 2'b11, tc[i].nul, 2'b00}, d[7:0])
            peek(7'h11, v);
            `CHK("follower", tc[i].f11, v)
        end
    endtask

    task automatic sc_unmapped;
        logic [31:0] d;
        logic        e;
        apb(1'b0, 8'h24, 32'h0000_0000, d, e);
        `CHK("slverr", 1'b1, e)
        `CHK("unmapped_data", 32'h0000_0000, d)
    endtask

    // ********************************
    // main sequence
    // ********************************
    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        sc_watchdog();
        sc_call();
        sc_ops();
        sc_unmapped();
        wrap_up();
    end
endmodule
`default_nettype wire
